// ---- dtp_defines.svh ----
// register offsets, field positions, reset values and timing counts of the dual timer
`ifndef DTP_DEFINES_SVH
`define DTP_DEFINES_SVH

`define DTP_OFS_CTRL0 6'h00
`define DTP_OFS_CTRL1 6'h04
`define DTP_OFS_CSEL0 6'h08
`define DTP_OFS_CSEL1 6'h0C
`define DTP_OFS_CMP0 6'h10
`define DTP_OFS_CMP1 6'h14
`define DTP_OFS_CNT0 6'h18
`define DTP_OFS_CNT1 6'h1C

`define DTP_BIT_RUN 7
`define DTP_BIT_PWM 6
`define DTP_BIT_CASC 4
`define DTP_BIT_OSET 3
`define DTP_BIT_ORST 2
`define DTP_BIT_LVL 1
`define DTP_BIT_OE 0

`define DTP_CTRL0_MASK 8'hC3
`define DTP_CTRL1_MASK 8'hD3
`define DTP_CTRL_RST 8'h00
`define DTP_CSEL_RST 3'h0
`define DTP_CMP_RST 8'h00
`define DTP_CNT_LAST 8'hFF
`define DTP_CNT_STAGE 8'hFE
`define DTP_PRESC_W 7

`endif

// ---- dtp_pkg.sv ----
// types shared by the dual timer
`default_nettype none
package dtp_pkg;
   typedef logic [7:0] dtp_byte_type;
   typedef enum logic [1:0] {
      DTP_MODE_INTERVAL,
      DTP_MODE_PWM,
      DTP_MODE_CASCADE
   } dtp_mode_type;
endpackage
`default_nettype wire

// ---- dtp_timer.sv ----
// dual 8-bit timer with pwm and 16-bit cascade, avalon-mm register slave
//
// Function
// RULE_01 - software spaces compare writes three count clocks
// RULE_02 - software sets pwm, level, enable while stopped
// RULE_03 - pwm output inactive until first overflow
// RULE_04 - overflow drives pwm output to active level
// RULE_05 - compare match returns pwm output inactive
// RULE_06 - clearing run makes pwm output inactive
// RULE_07 - period 256 clocks, active width N
// RULE_08 - write before FFH edge reloads next overflow
// RULE_09 - write after FFH edge reloads second overflow
// RULE_10 - pending compare reads new, compares old
// RULE_11 - software sets cascade bit, clear-on-match, stopped
// RULE_12 - cascade counter uses channel 0 clock only
// RULE_13 - cascade compare is high and low bytes
// RULE_14 - cascade match raises irq, clears counter
// RULE_15 - software starts high first, stops low first
// RULE_16 - software keeps channel 1 output bits zero
// RULE_17 - event code 00H falling, 01H rising
// RULE_18 - cascade match toggles output flip-flop
// RULE_19 - first match may slip one count clock
// RULE_20 - software keeps cascade compare during counting
// RULE_21 - output disabled holds pin low
// RULE_22 - output set and reset bits read zero
// RULE_23 - pwm counter wraps FFH to 00H
//
// The address map and the Avalon-MM interface to the registers were decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "dtp_defines.svh"

module dtp_timer (
   input wire logic clk_sys_i,
   input wire logic sys_rst_i,
   input wire logic [5:0] avs_address_i,
   input wire logic avs_read_i,
   input wire logic avs_write_i,
   input wire logic [31:0] avs_writedata_i,
   input wire logic [3:0] avs_byteenable_i,
   output logic [31:0] avs_readdata_o,
   output logic avs_waitrequest_o,
   input wire logic [1:0] event_in_pin_i,
   output logic [1:0] timer_out_pin_o,
   output logic [1:0] match_irq_o
);

   // prescaled tick: code k >= 2 divides the system clock by 2^(k-1)
   function automatic logic sel_tick(input logic [2:0] code,
                                     input logic [`DTP_PRESC_W-1:0] pre,
                                     input logic rise,
                                     input logic fall);
      logic [`DTP_PRESC_W-1:0] mask;
      mask = 7'((8'h01 << (code - 3'h1)) - 8'h01);
      case (code)
         3'h0: sel_tick = fall;
         3'h1: sel_tick = rise;
         default: sel_tick = &(pre | ~mask);
      endcase
   endfunction

   dtp_pkg::dtp_byte_type ctrl_ff [2];
   dtp_pkg::dtp_byte_type cmp_ff [2];
   dtp_pkg::dtp_byte_type cnt_ff [2];
   dtp_pkg::dtp_byte_type act_ff [2];
   dtp_pkg::dtp_byte_type stage_ff [2];
   dtp_pkg::dtp_byte_type nxt_cnt [2];
   dtp_pkg::dtp_byte_type nxt_act [2];
   dtp_pkg::dtp_byte_type nxt_stage [2];
   logic [2:0] csel_ff [2];
   logic [1:0] tff_ff, nxt_tff;
   logic [1:0] pon_ff, nxt_pon;
   logic [1:0] pin_ff, nxt_pin;
   logic [1:0] irq_ff, nxt_irq;
   logic [1:0] sync1_ff, sync2_ff, sync3_ff;
   logic [`DTP_PRESC_W-1:0] presc_ff;
   logic waitreq_ff;
   logic [31:0] rdata_ff;
   logic [15:0] cnt16, cmp16, cnt16_inc;

   // bus decode: answer one cycle after the request is seen
   wire req_w = avs_read_i | avs_write_i;
   wire do_wr = avs_write_i & ~waitreq_ff & avs_byteenable_i[0];
   wire wr_ctrl0 = do_wr & (avs_address_i == `DTP_OFS_CTRL0);
   wire wr_ctrl1 = do_wr & (avs_address_i == `DTP_OFS_CTRL1);
   wire wr_csel0 = do_wr & (avs_address_i == `DTP_OFS_CSEL0);
   wire wr_csel1 = do_wr & (avs_address_i == `DTP_OFS_CSEL1);
   wire wr_cmp0 = do_wr & (avs_address_i == `DTP_OFS_CMP0);
   wire wr_cmp1 = do_wr & (avs_address_i == `DTP_OFS_CMP1);
   wire [1:0] wr_ctrl = {wr_ctrl1, wr_ctrl0};
   wire [7:0] wbyte = avs_writedata_i[7:0];

   // set/reset bits are never stored, so they read back zero [RULE_22]
   wire [7:0] rd_byte =
      (avs_address_i == `DTP_OFS_CTRL0) ? ctrl_ff[0] :
      (avs_address_i == `DTP_OFS_CTRL1) ? ctrl_ff[1] :
      (avs_address_i == `DTP_OFS_CSEL0) ? {5'h00, csel_ff[0]} :
      (avs_address_i == `DTP_OFS_CSEL1) ? {5'h00, csel_ff[1]} :
      (avs_address_i == `DTP_OFS_CMP0) ? cmp_ff[0] :
      (avs_address_i == `DTP_OFS_CMP1) ? cmp_ff[1] :
      (avs_address_i == `DTP_OFS_CNT0) ? cnt_ff[0] :
      (avs_address_i == `DTP_OFS_CNT1) ? cnt_ff[1] : 8'h00;

   // event edges come from the second and third stages only
   wire [1:0] ev_rise = sync2_ff & ~sync3_ff;
   wire [1:0] ev_fall = ~sync2_ff & sync3_ff;
   // the prescaler runs free, so the first tick after start may land anywhere [RULE_19]
   wire [1:0] src_tick = {sel_tick(csel_ff[1], presc_ff, ev_rise[1], ev_fall[1]),
                          sel_tick(csel_ff[0], presc_ff, ev_rise[0], ev_fall[0])}; // [RULE_17]
   wire casc = ctrl_ff[1][`DTP_BIT_CASC];
   // in cascade both bytes follow the channel 0 selector [RULE_12]
   wire [1:0] tick = casc ? {src_tick[0], src_tick[0]} : src_tick;
   wire [1:0] run = {ctrl_ff[1][`DTP_BIT_RUN], ctrl_ff[0][`DTP_BIT_RUN]};
   wire [1:0] pwm = {ctrl_ff[1][`DTP_BIT_PWM], ctrl_ff[0][`DTP_BIT_PWM]};
   wire [1:0] lvl = {ctrl_ff[1][`DTP_BIT_LVL], ctrl_ff[0][`DTP_BIT_LVL]};
   wire [1:0] oe = {ctrl_ff[1][`DTP_BIT_OE], ctrl_ff[0][`DTP_BIT_OE]};
   wire casc_run = run[0] & run[1];

   dtp_pkg::dtp_mode_type mode_w [2];
   assign mode_w[0] = casc ? dtp_pkg::DTP_MODE_CASCADE :
                      (pwm[0] ? dtp_pkg::DTP_MODE_PWM : dtp_pkg::DTP_MODE_INTERVAL);
   assign mode_w[1] = casc ? dtp_pkg::DTP_MODE_CASCADE :
                      (pwm[1] ? dtp_pkg::DTP_MODE_PWM : dtp_pkg::DTP_MODE_INTERVAL);

   assign cnt16 = {cnt_ff[1], cnt_ff[0]};
   assign cmp16 = {cmp_ff[1], cmp_ff[0]}; // [RULE_13]
   assign cnt16_inc = cnt16 + 16'h0001;

   always_comb begin
      for (int i = 0; i < 2; i++) begin
         nxt_cnt[i] = cnt_ff[i];
         nxt_act[i] = act_ff[i];
         nxt_stage[i] = stage_ff[i];
         nxt_tff[i] = tff_ff[i];
         nxt_pon[i] = pon_ff[i];
         nxt_irq[i] = 1'b0;
         case (mode_w[i])
            dtp_pkg::DTP_MODE_PWM: begin
               if (!run[i]) begin
                  nxt_cnt[i] = 8'h00;
                  nxt_pon[i] = 1'b0; // [RULE_03] [RULE_06]
               end else if (tick[i]) begin
                  nxt_cnt[i] = cnt_ff[i] + 8'h01; // [RULE_23] [RULE_07]
                  if (cnt_ff[i] == `DTP_CNT_STAGE) begin
                     nxt_stage[i] = cmp_ff[i]; // [RULE_08] [RULE_09]
                  end
                  if (cnt_ff[i] == `DTP_CNT_LAST) begin
                     nxt_act[i] = stage_ff[i]; // [RULE_10]
                     nxt_pon[i] = (stage_ff[i] != 8'h00); // [RULE_04]
                  end else if (cnt_ff[i] + 8'h01 == act_ff[i]) begin
                     nxt_pon[i] = 1'b0; // [RULE_05]
                  end
               end
            end
            dtp_pkg::DTP_MODE_INTERVAL: begin
               nxt_pon[i] = 1'b0;
               if (!run[i]) begin
                  nxt_cnt[i] = 8'h00;
               end else if (tick[i]) begin
                  if (cnt_ff[i] == cmp_ff[i]) begin
                     nxt_cnt[i] = 8'h00;
                     nxt_irq[i] = 1'b1;
                     if (lvl[i]) begin
                        nxt_tff[i] = ~tff_ff[i];
                     end
                  end else begin
                     nxt_cnt[i] = cnt_ff[i] + 8'h01;
                  end
               end
            end
            default: begin
               nxt_pon[i] = 1'b0;
            end
         endcase
         // set/reset only act outside pwm; a write wins over a same-cycle toggle
         if (wr_ctrl[i] && !wbyte[`DTP_BIT_PWM]) begin
            if (wbyte[`DTP_BIT_OSET]) begin
               nxt_tff[i] = 1'b1;
            end else if (wbyte[`DTP_BIT_ORST]) begin
               nxt_tff[i] = 1'b0;
            end
         end
      end
      if (casc) begin
         if (!casc_run) begin
            nxt_cnt[0] = 8'h00;
            nxt_cnt[1] = 8'h00;
         end else if (tick[0]) begin
            if (cnt16 == cmp16) begin
               nxt_cnt[0] = 8'h00; // [RULE_14]
               nxt_cnt[1] = 8'h00;
               nxt_irq[0] = 1'b1;
               if (lvl[0] && !(wr_ctrl0 && (wbyte[`DTP_BIT_OSET] || wbyte[`DTP_BIT_ORST]))) begin
                  nxt_tff[0] = ~tff_ff[0]; // [RULE_18]
               end
            end else begin
               nxt_cnt[0] = cnt16_inc[7:0];
               nxt_cnt[1] = cnt16_inc[15:8];
            end
         end
      end
      for (int i = 0; i < 2; i++) begin
         // pin is low whenever output is disabled [RULE_21]
         nxt_pin[i] = oe[i] & (pwm[i] & !casc ? (nxt_pon[i] ^ lvl[i]) : nxt_tff[i]);
      end
   end

   always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         waitreq_ff <= 1'b1;
         rdata_ff <= 32'h0000_0000;
      end else begin
         waitreq_ff <= ~(req_w & waitreq_ff);
         if (avs_read_i && waitreq_ff) begin
            rdata_ff <= {24'h00_0000, rd_byte};
         end
      end
   end

   always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         for (int i = 0; i < 2; i++) begin
            ctrl_ff[i] <= `DTP_CTRL_RST;
            csel_ff[i] <= `DTP_CSEL_RST;
            cmp_ff[i] <= `DTP_CMP_RST;
         end
      end else begin
         if (wr_ctrl0) ctrl_ff[0] <= wbyte & `DTP_CTRL0_MASK;
         if (wr_ctrl1) ctrl_ff[1] <= wbyte & `DTP_CTRL1_MASK;
         if (wr_csel0) csel_ff[0] <= wbyte[2:0];
         if (wr_csel1) csel_ff[1] <= wbyte[2:0];
         // new compare lands here at once; pwm comparison waits for reload, interval and cascade compare it at once [RULE_10]
         if (wr_cmp0) cmp_ff[0] <= wbyte;
         if (wr_cmp1) cmp_ff[1] <= wbyte;
      end
   end

   always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         for (int i = 0; i < 2; i++) begin
            cnt_ff[i] <= 8'h00;
            act_ff[i] <= `DTP_CMP_RST;
            stage_ff[i] <= `DTP_CMP_RST;
         end
         tff_ff <= 2'b00;
         pon_ff <= 2'b00;
         pin_ff <= 2'b00;
         irq_ff <= 2'b00;
         sync1_ff <= 2'b00;
         sync2_ff <= 2'b00;
         sync3_ff <= 2'b00;
         presc_ff <= '0;
      end else begin
         cnt_ff <= nxt_cnt;
         act_ff <= nxt_act;
         stage_ff <= nxt_stage;
         tff_ff <= nxt_tff;
         pon_ff <= nxt_pon;
         pin_ff <= nxt_pin;
         irq_ff <= nxt_irq;
         sync1_ff <= event_in_pin_i;
         sync2_ff <= sync1_ff;
         sync3_ff <= sync2_ff;
         presc_ff <= presc_ff + 7'h01;
      end
   end

   assign avs_readdata_o = rdata_ff;
   assign avs_waitrequest_o = waitreq_ff;
   assign timer_out_pin_o = pin_ff;
   assign match_irq_o = irq_ff;

   default clocking cb_sys @(posedge clk_sys_i); endclocking
   default disable iff (sys_rst_i);

   property p_oe_low;
      !oe[0] |=> !timer_out_pin_o[0];
   endproperty
   a_oe_low: assert property (p_oe_low) else $error("pin not low while disabled"); // [RULE_21]

   property p_stop_inactive;
      (mode_w[0] == dtp_pkg::DTP_MODE_PWM) && !run[0] && $stable(ctrl_ff[0])
         |=> !pon_ff[0] && (timer_out_pin_o[0] == ($past(oe[0]) & $past(lvl[0])));
   endproperty
   a_stop_inactive: assert property (p_stop_inactive) else $error("pwm not inactive"); // [RULE_06]

   property p_start_inactive;
      // active can only begin at an overflow, so a fresh start stays inactive
      $rose(pon_ff[0])
         |-> $past(tick[0]) && ($past(cnt_ff[0]) == `DTP_CNT_LAST);
   endproperty
   a_start_inactive: assert property (p_start_inactive) else $error("early active"); // [RULE_03]

   property p_overflow_active;
      (mode_w[0] == dtp_pkg::DTP_MODE_PWM) && run[0] && tick[0]
         && cnt_ff[0] == `DTP_CNT_LAST && stage_ff[0] != 8'h00
         |=> pon_ff[0] && cnt_ff[0] == 8'h00;
   endproperty
   a_overflow_active: assert property (p_overflow_active) else $error("no active"); // [RULE_04]

   property p_match_inactive;
      (mode_w[0] == dtp_pkg::DTP_MODE_PWM) && run[0] && tick[0]
         && cnt_ff[0] != `DTP_CNT_LAST && cnt_ff[0] + 8'h01 == act_ff[0]
         |=> !pon_ff[0];
   endproperty
   a_match_inactive: assert property (p_match_inactive) else $error("no inactive"); // [RULE_05]

   property p_reload;
      (mode_w[0] == dtp_pkg::DTP_MODE_PWM) && run[0] && tick[0] && cnt_ff[0] == `DTP_CNT_LAST
         |=> act_ff[0] == $past(stage_ff[0]);
   endproperty
   a_reload: assert property (p_reload) else $error("compare not reloaded"); // [RULE_08]

   property p_stage;
      (mode_w[0] == dtp_pkg::DTP_MODE_PWM) && run[0] && tick[0] && cnt_ff[0] == `DTP_CNT_STAGE
         |=> stage_ff[0] == $past(cmp_ff[0]);
   endproperty
   a_stage: assert property (p_stage) else $error("compare not staged"); // [RULE_09]

   property p_pending;
      wr_cmp0 && !tick[0] |=> cmp_ff[0] == $past(wbyte) && $stable(act_ff[0]);
   endproperty
   a_pending: assert property (p_pending) else $error("pending compare wrong"); // [RULE_10]

   property p_casc_match;
      casc && casc_run && tick[0] && cnt16 == cmp16
         |=> cnt16 == 16'h0000 && match_irq_o[0] && !match_irq_o[1];
   endproperty
   a_casc_match: assert property (p_casc_match) else $error("cascade match lost"); // [RULE_14]

   property p_casc_toggle;
      casc && casc_run && tick[0] && cnt16 == cmp16 && lvl[0] && !wr_ctrl0
         |=> tff_ff[0] != $past(tff_ff[0]);
   endproperty
   a_casc_toggle: assert property (p_casc_toggle) else $error("no toggle"); // [RULE_18]

   property p_rd_zero;
      avs_read_i && waitreq_ff && avs_address_i == `DTP_OFS_CTRL0
         |=> !avs_waitrequest_o && avs_readdata_o[3:2] == 2'b00;
   endproperty
   a_rd_zero: assert property (p_rd_zero) else $error("set/reset read nonzero"); // [RULE_22]

endmodule // dtp_timer
`default_nettype wire

// ---- dtp_ext_src.sv ----
// event pulse source and output pin watcher beside the dual timer
`timescale 1ns/1ps
`default_nettype none
module dtp_ext_src (
   input wire logic clk_i,
   input wire logic [1:0] pin_i,
   output logic [1:0] ev_o,
   output int toggles_o
);
   logic ev0 = 1'b1;
   logic ev1 = 1'b0;
   logic last = 1'b0;
   assign ev_o = {ev1, ev0};
   initial toggles_o = 0;
   // channel 1 input keeps moving, so a cascade that listens to it shows up
   always begin
      repeat (4) @(posedge clk_i);
      ev1 <= ~ev1;
   end
   always @(posedge clk_i) begin
      last <= pin_i[0];
      if (pin_i[0] !== last) toggles_o <= toggles_o + 1;
   end
   // four clocks per level keeps the line well inside the synchroniser limit
   task automatic burst(input int n);
      for (int i = 0; i < n; i++) begin
         repeat (4) @(posedge clk_i);
         ev0 <= ~ev0;
      end
   endtask
endmodule // dtp_ext_src
`default_nettype wire

// ---- dtp_timer_tb.sv ----
// self-checking bench of the dual timer
`timescale 1ns/1ps
`default_nettype none
`include "dtp_defines.svh"
`define CHK(got, exp) begin n_compared++; if ((got) !== (exp)) begin miscompares++; \
   $display("Error at %0t: got %h expected %h", $time, got, exp); end end
module dtp_timer_tb;
   localparam int T = 16;
   logic clk_sys_i = 1'b0;
   logic sys_rst_i = 1'b1;
   logic [5:0] addr = 6'h00;
   logic rd = 1'b0;
   logic wr = 1'b0;
   logic [31:0] wdata = 32'h0;
   logic [31:0] rdata;
   logic wait_req;
   logic [1:0] ev;
   logic [1:0] pin;
   logic [1:0] irq;
   int toggles;
   int miscompares = 0;
   int n_compared = 0;
   int cycles = 0;
   int irq0 = 0;
   int irq1 = 0;
   logic [7:0] exp_reg [8];
   logic [7:0] sr_seq [4] = '{8'h09, 8'h08, 8'h01, 8'h05};
   logic sr_pin [4] = '{1'b1, 1'b0, 1'b1, 1'b0};

   dtp_timer uut (.clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i), .avs_address_i(addr),
      .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wdata),
      .avs_byteenable_i(4'hF), .avs_readdata_o(rdata), .avs_waitrequest_o(wait_req),
      .event_in_pin_i(ev), .timer_out_pin_o(pin), .match_irq_o(irq));
   dtp_ext_src src (.clk_i(clk_sys_i), .pin_i(pin), .ev_o(ev), .toggles_o(toggles));

   always #2 clk_sys_i = ~clk_sys_i;

   always @(posedge clk_sys_i) begin
      cycles++;
      if (irq[0] === 1'b1) irq0++;
      if (irq[1] === 1'b1) irq1++;
      if (cycles == 70000) begin
         miscompares++;
         results();
      end
   end

   task automatic results;
      if (miscompares == 0 && n_compared > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   function automatic logic [7:0] wmask(input logic [5:0] a);
      case (a)
         `DTP_OFS_CTRL0: return `DTP_CTRL0_MASK;
         `DTP_OFS_CTRL1: return `DTP_CTRL1_MASK;
         `DTP_OFS_CSEL0, `DTP_OFS_CSEL1: return 8'h07;
         `DTP_OFS_CMP0, `DTP_OFS_CMP1: return 8'hFF;
         default: return 8'h00;
      endcase
   endfunction

   // upper data bits are random noise that the slave must ignore
   task automatic bus(input logic w, input logic [5:0] a, input logic [7:0] d,
                      output logic [31:0] q);
      logic [23:0] r;
      r = 24'($urandom());
      @(posedge clk_sys_i);
      addr <= a;
      wdata <= {r, d};
      rd <= ~w;
      wr <= w;
      // only the bench timeout ends a slave that never answers
      do begin
         @(posedge clk_sys_i);
      end while (wait_req !== 1'b0);
      q = rdata;
      rd <= 1'b0;
      wr <= 1'b0;
   endtask

   task automatic wr_reg(input logic [5:0] a, input logic [7:0] d);
      logic [31:0] q;
      bus(1'b1, a, d, q);
      if (a < 6'h20) exp_reg[a[4:2]] = d & wmask(a);
   endtask

   task automatic rd_chk(input logic [5:0] a);
      logic [31:0] q;
      bus(1'b0, a, 8'h00, q);
      `CHK(q, {24'h0, (a < 6'h20) ? exp_reg[a[4:2]] : 8'h00})
   endtask

   task automatic wait_pin(input logic v, output int t);
      t = 0;
      while (pin[0] !== v && t < 5000) begin
         @(posedge clk_sys_i);
         t++;
      end
      if (t >= 5000) miscompares++;
   endtask

   task automatic pwm_run(input logic lvl);
      logic [7:0] n;
      int t;
      n = 8'(1 + $urandom() % 254);
      wr_reg(`DTP_OFS_CSEL0, 8'h05);
      wr_reg(`DTP_OFS_CMP0, n);
      wr_reg(`DTP_OFS_CTRL0, {6'b010000, lvl, 1'b1});
      repeat (3) @(posedge clk_sys_i);
      `CHK(pin[0], lvl)
      wr_reg(`DTP_OFS_CTRL0, {6'b110000, lvl, 1'b1});
      wait_pin(~lvl, t);
      `CHK(t >= 255 * T && t <= 258 * T, 1'b1)
      wait_pin(lvl, t);
      `CHK(t, int'(n) * T)
      wait_pin(~lvl, t);
      `CHK(t, (256 - int'(n)) * T)
      wr_reg(`DTP_OFS_CTRL0, {6'b010000, lvl, 1'b1});
      repeat (3) @(posedge clk_sys_i);
      `CHK(pin[0], lvl)
   endtask

   task automatic reload;
      logic [7:0] m;
      logic [7:0] p;
      logic [31:0] q;
      int t;
      m = 8'(1 + $urandom() % 254);
      p = 8'(1 + $urandom() % 254);
      wr_reg(`DTP_OFS_CMP0, 8'h20);
      wr_reg(`DTP_OFS_CTRL0, 8'h41);
      wr_reg(`DTP_OFS_CTRL0, 8'hC1);
      wait_pin(1'b1, t);
      wait_pin(1'b0, t);
      wr_reg(`DTP_OFS_CMP0, m);
      wait_pin(1'b1, t);
      wait_pin(1'b0, t);
      `CHK(t, int'(m) * T)
      // a slow count clock leaves room to land the write inside the FFH tick
      q = 32'h0;
      for (int i = 0; i < 2000 && q[7:0] !== 8'hFF; i++) bus(1'b0, `DTP_OFS_CNT0, 8'h00, q);
      wr_reg(`DTP_OFS_CMP0, p);
      wait_pin(1'b1, t);
      wait_pin(1'b0, t);
      `CHK(t, int'(m) * T)
      rd_chk(`DTP_OFS_CMP0);
      wait_pin(1'b1, t);
      wait_pin(1'b0, t);
      `CHK(t, int'(p) * T)
      wr_reg(`DTP_OFS_CTRL0, 8'h41);
   endtask

   task automatic cascade(input logic code);
      logic [15:0] n;
      int i0;
      int tg;
      n = 16'h0100 | 16'($urandom() % 64);
      wr_reg(`DTP_OFS_CSEL0, {7'h00, code});
      wr_reg(`DTP_OFS_CSEL1, 8'h02);
      wr_reg(`DTP_OFS_CMP0, n[7:0]);
      wr_reg(`DTP_OFS_CMP1, n[15:8]);
      wr_reg(`DTP_OFS_CTRL0, 8'h07);
      wr_reg(`DTP_OFS_CTRL1, 8'h10);
      wr_reg(`DTP_OFS_CTRL1, 8'h90);
      wr_reg(`DTP_OFS_CTRL0, 8'h83);
      i0 = irq0;
      tg = toggles;
      // one edge short of the wrong polarity reaching its second match
      src.burst(4 * (int'(n) + 1) - 1);
      repeat (20) @(posedge clk_sys_i);
      `CHK(irq0 - i0, 2)
      `CHK(toggles - tg, 2)
      `CHK(irq1, 0)
      `CHK(pin[1], 1'b0)
      wr_reg(`DTP_OFS_CTRL0, 8'h03);
      wr_reg(`DTP_OFS_CTRL1, 8'h10);
   endtask

   initial begin
      void'($urandom(68));
      for (int i = 0; i < 8; i++) exp_reg[i] = 8'h00;
      repeat (6) @(posedge clk_sys_i);
      `CHK(wait_req, 1'b1)
      `CHK(pin, 2'b00)
      sys_rst_i <= 1'b0;
      for (int a = 0; a <= 32; a += 4) rd_chk(6'(a));
      wr_reg(6'h20, 8'h5A);
      rd_chk(6'h20);
      for (int i = 0; i < 4; i++) begin
         wr_reg(`DTP_OFS_CTRL0, sr_seq[i]);
         repeat (2) @(posedge clk_sys_i);
         `CHK(pin[0], sr_pin[i])
         rd_chk(`DTP_OFS_CTRL0);
      end
      pwm_run(1'b0);
      pwm_run(1'b1);
      reload();
      cascade(1'b0);
      cascade(1'b1);
      results();
   end
endmodule // dtp_timer_tb
`default_nettype wire
